/* rtl/dgw_group_ctrl.sv */
// Added by the designer: the address map and strobed register access.
`timescale 1ns/100ps
`include "dgw_defines.svh"

module dgw_group_ctrl #(
    parameter int FIFO_DEPTH = 8192 // Sample buffer entries
) (
    input wire logic clk, // 25 MHz clock
    input wire logic rst_n, // Asynchronous reset
    input wire logic [7:0] addr, // Register byte address
    input wire logic [31:0] wdata, // Register write data
    input wire logic wr_en, // Write strobe
    input wire logic rd_en, // Read strobe
    output logic [31:0] rdata, // Read data, cycle after strobe
    input wire logic ext_dig_trig, // External digital trigger pin
    input wire logic analog_trig, // Analog trigger comparator
    input wire logic sync_bus_trigger, // Sync bus start trigger
    input wire logic ext_update, // External update pin
    input wire logic sync_bus_update, // Sync bus update
    output dgw_pkg::dgw_code_t dac_data, // Code to converter
    output logic [1:0] dac_sel, // Target converter
    output logic dac_write_strobe, // Data taken on falling edge
    output logic dac_latch, // Updates all outputs together
    output logic [3:0] dac_ref_sel, // Per-channel reference select
    output logic [3:0] dac_bipolar, // Per-channel bipolar mode
    output logic dma_req, // Buffer below half in waveform mode
    output logic fifo_full // Buffer full
);
    import dgw_pkg::*;

    localparam int AW = $clog2(FIFO_DEPTH);
    localparam logic [AW:0] DEPTH = (AW + 1)'(FIFO_DEPTH);
    localparam logic [7:0] MIN_GAP = 8'(`DGW_MIN_UPDATE_CYC);

    typedef struct packed {
        dgw_state_t state;
        logic wave_mode;
        dgw_start_src_t start_src;
        dgw_strobe_src_t strobe_src;
        dgw_stop_src_t stop_src;
        logic [3:0] ch_en;
        logic [3:0] ref_sel;
        logic [3:0] bipolar;
        logic [23:0] interval;
        logic [3:0][11:0] sw_code;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
        logic [1:0] ch_idx;
        logic phase;
        logic from_fifo;
        logic stop_pend;
        logic underrun;
        logic overflow;
        logic [4:0] sync1;
        logic [4:0] sync2;
        logic [4:0] sync3;
        logic [7:0] gap;
        logic [31:0] rdata;
        logic [11:0] dac_data;
        logic [1:0] dac_sel;
        logic dac_strobe;
        logic dac_latch;
        logic dma_req;
        logic full;
    } dgw_regs_t;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic dgw_regs_t regs_rst();
        dgw_regs_t r;
        r = '0;
        r.interval = 24'(`DGW_MIN_UPDATE_CYC);
        r.sw_code = {4{`DGW_CODE_MID}};
        return r;
    endfunction

    localparam dgw_regs_t REGS_RST = regs_rst();

    // First enabled channel at or above start, 4 when none
    function automatic logic [2:0] next_ch(input logic [3:0] en, input logic [2:0] start);
        logic [2:0] res;
        res = 3'h4;
        for (int i = 3; i >= 0; i--) begin
            if (en[i] && 3'(i) >= start) begin
                res = 3'(i);
            end
        end
        return res;
    endfunction

    function automatic logic [2:0] n_en(input logic [3:0] en);
        logic [2:0] n;
        n = 3'h0;
        for (int i = 0; i < 4; i++) begin
            n = n + {2'h0, en[i]};
        end
        return n;
    endfunction

    dgw_regs_t regs_q;
    dgw_regs_t regs_d;
    logic [11:0] mem [FIFO_DEPTH];
    logic [11:0] mem_q;
    logic push;
    logic tick;
    logic timer_run;
    logic [4:0] rise;
    logic [4:0] fall;
    logic [5:0] cmd;
    logic start_evt;
    logic stop_evt;
    logic strobe_evt;

    // ****************************************
    // Update timer
    // ****************************************
    assign timer_run = regs_q.strobe_src == DGW_STROBE_INT && regs_q.state != DGW_IDLE
        && regs_q.state != DGW_ARMED;

    dgw_update_timer u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .run(timer_run),
        .interval(regs_q.interval),
        .tick(tick)
    );

    // ****************************************
    // Event decode
    // ****************************************
    assign rise = regs_q.sync2 & ~regs_q.sync3;
    assign fall = ~regs_q.sync2 & regs_q.sync3;
    assign cmd = (wr_en && addr == `DGW_REG_CMD) ? wdata[5:0] : 6'h00;
    assign push = wr_en && addr == `DGW_REG_FIFO && !regs_q.full;

    always_comb begin
        unique case (regs_q.start_src)
            DGW_START_SW: start_evt = cmd[`DGW_CMD_SW_START];
            DGW_START_EXT: start_evt = rise[0];
            DGW_START_ANALOG: start_evt = rise[1];
            DGW_START_SYNC: start_evt = rise[2];
        endcase
        unique case (regs_q.stop_src)
            DGW_STOP_SW: stop_evt = cmd[`DGW_CMD_SW_STOP];
            DGW_STOP_EXT: stop_evt = rise[0];
            DGW_STOP_ANALOG: stop_evt = rise[1];
            DGW_STOP_NONE: stop_evt = 1'b0;
        endcase
        unique case (regs_q.strobe_src)
            DGW_STROBE_INT: strobe_evt = tick;
            DGW_STROBE_EXT: strobe_evt = fall[3];
            DGW_STROBE_SYNC: strobe_evt = fall[4];
            DGW_STROBE_OFF: strobe_evt = 1'b0;
        endcase
        // Too-fast external strobes are dropped, not queued
        strobe_evt = strobe_evt && regs_q.gap >= MIN_GAP;
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic pop;
        logic [2:0] nxt;
        pop = 1'b0;
        nxt = 3'h0;
        regs_d = regs_q;
        regs_d.sync1 = {sync_bus_update, ext_update, sync_bus_trigger, analog_trig, ext_dig_trig};
        regs_d.sync2 = regs_q.sync1;
        regs_d.sync3 = regs_q.sync2;
        regs_d.rdata = 32'h00000000;
        regs_d.dac_strobe = 1'b0;
        regs_d.dac_latch = 1'b0;
        if (regs_q.gap != 8'hff) begin
            regs_d.gap = regs_q.gap + 8'h01;
        end

        if (wr_en) begin
            unique case (addr)
                `DGW_REG_CTRL: begin
                    regs_d.wave_mode = wdata[`DGW_CTRL_WAVE];
                    regs_d.start_src = dgw_start_src_t'(wdata[`DGW_CTRL_START_LSB +: 2]);
                    regs_d.strobe_src = dgw_strobe_src_t'(wdata[`DGW_CTRL_STROBE_LSB +: 2]);
                    regs_d.stop_src = dgw_stop_src_t'(wdata[`DGW_CTRL_STOP_LSB +: 2]);
                end
                `DGW_REG_CHAN: begin
                    regs_d.ch_en = wdata[`DGW_CHAN_EN_LSB +: 4];
                    regs_d.ref_sel = wdata[`DGW_CHAN_REF_LSB +: 4];
                    regs_d.bipolar = wdata[`DGW_CHAN_BIP_LSB +: 4];
                end
                `DGW_REG_INTERVAL: regs_d.interval = wdata[23:0];
                default: begin
                    if ({addr[7:4], 4'h0} == `DGW_REG_SWCODE && addr[1:0] == 2'h0) begin
                        regs_d.sw_code[addr[3:2]] = wdata[11:0];
                    end
                end
            endcase
        end

        if (rd_en) begin
            unique case (addr)
                `DGW_REG_CTRL: regs_d.rdata = {25'h0, regs_q.stop_src, regs_q.strobe_src, regs_q.start_src,
                    regs_q.wave_mode};
                `DGW_REG_CHAN: regs_d.rdata = {20'h0, regs_q.bipolar, regs_q.ref_sel, regs_q.ch_en};
                `DGW_REG_INTERVAL: regs_d.rdata = {8'h0, regs_q.interval};
                `DGW_REG_STATUS: regs_d.rdata = 32'({regs_q.count, regs_q.full, regs_q.count == '0,
                    regs_q.overflow, regs_q.underrun, regs_q.state != DGW_IDLE, regs_q.state});
                default: begin
                    if ({addr[7:4], 4'h0} == `DGW_REG_SWCODE && addr[1:0] == 2'h0) begin
                        regs_d.rdata = {20'h0, regs_q.sw_code[addr[3:2]]};
                    end
                end
            endcase
        end

        // Sequencer
        unique case (regs_q.state)
            DGW_IDLE: begin
                regs_d.stop_pend = 1'b0;
                if (regs_q.wave_mode && cmd[`DGW_CMD_ARM]) begin
                    regs_d.state = DGW_ARMED;
                end else if (!regs_q.wave_mode && cmd[`DGW_CMD_SW_UPDATE] && regs_q.ch_en != 4'h0) begin
                    regs_d.from_fifo = 1'b0;
                    nxt = next_ch(regs_q.ch_en, 3'h0);
                    regs_d.ch_idx = nxt[1:0];
                    regs_d.phase = 1'b0;
                    regs_d.state = DGW_SHIFT;
                end
            end
            DGW_ARMED: begin
                // Start wins, so one shared pin can both start and stop
                if (start_evt) begin
                    regs_d.state = DGW_RUN;
                end else if (stop_evt) begin
                    regs_d.state = DGW_IDLE;
                end
            end
            DGW_RUN: begin
                // Further starts fall through unheard here
                if (stop_evt || regs_q.stop_pend) begin
                    regs_d.state = DGW_IDLE;
                end else if (strobe_evt) begin
                    regs_d.gap = 8'h00;
                    if (regs_q.ch_en != 4'h0) begin
                        // Whole set must be present, else no channel moves
                        if (regs_q.count >= (AW + 1)'(n_en(regs_q.ch_en))) begin
                            regs_d.from_fifo = 1'b1;
                            nxt = next_ch(regs_q.ch_en, 3'h0);
                            regs_d.ch_idx = nxt[1:0];
                            regs_d.state = DGW_FETCH;
                        end else begin
                            regs_d.underrun = 1'b1;
                        end
                    end
                end
            end
            DGW_FETCH: begin
                regs_d.phase = 1'b0;
                regs_d.state = DGW_SHIFT;
            end
            DGW_SHIFT: begin
                if (!regs_q.phase) begin
                    regs_d.dac_data = regs_q.from_fifo ? mem_q : regs_q.sw_code[regs_q.ch_idx];
                    regs_d.dac_sel = regs_q.ch_idx;
                    regs_d.dac_strobe = 1'b1;
                    pop = regs_q.from_fifo;
                    regs_d.phase = 1'b1;
                end else begin
                    nxt = next_ch(regs_q.ch_en, {1'b0, regs_q.ch_idx} + 3'h1);
                    regs_d.phase = 1'b0;
                    if (nxt[2]) begin
                        regs_d.state = DGW_LATCH;
                    end else begin
                        regs_d.ch_idx = nxt[1:0];
                        regs_d.state = regs_q.from_fifo ? DGW_FETCH : DGW_SHIFT;
                    end
                end
            end
            DGW_LATCH: begin
                regs_d.dac_latch = 1'b1;
                regs_d.state = regs_q.from_fifo ? DGW_RUN : DGW_IDLE;
            end
            default: regs_d.state = DGW_IDLE;
        endcase

        // A stop in mid-update waits so the group never half-changes
        if (stop_evt && (regs_q.state == DGW_FETCH || regs_q.state == DGW_SHIFT
            || regs_q.state == DGW_LATCH)) begin
            regs_d.stop_pend = regs_q.from_fifo;
        end

        // Sample buffer pointers
        if (push) begin
            regs_d.wr_ptr = regs_q.wr_ptr + AW'(1);
        end
        if (pop) begin
            regs_d.rd_ptr = regs_q.rd_ptr + AW'(1);
        end
        if (push && !pop) begin
            regs_d.count = regs_q.count + (AW + 1)'(1);
        end else if (pop && !push) begin
            regs_d.count = regs_q.count - (AW + 1)'(1);
        end
        if (cmd[`DGW_CMD_FLUSH] && regs_q.state == DGW_IDLE) begin
            regs_d.wr_ptr = '0;
            regs_d.rd_ptr = '0;
            regs_d.count = '0;
        end

        // Flags: a fresh event beats a clear in the same cycle
        if (cmd[`DGW_CMD_CLEAR]) begin
            regs_d.overflow = 1'b0;
            if (regs_d.state == regs_q.state || regs_q.state != DGW_RUN) begin
                regs_d.underrun = 1'b0;
            end
        end
        if (regs_q.state == DGW_RUN && strobe_evt && regs_q.ch_en != 4'h0
            && regs_q.count < (AW + 1)'(n_en(regs_q.ch_en))) begin
            regs_d.underrun = 1'b1;
        end
        if (wr_en && addr == `DGW_REG_FIFO && regs_q.full) begin
            regs_d.overflow = 1'b1;
        end

        regs_d.full = regs_d.count == DEPTH;
        regs_d.dma_req = regs_d.wave_mode && regs_d.count < (DEPTH >> 1);
    end

    // ****************************************
    // Storage
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regs_q <= REGS_RST;
        end else begin
            regs_q <= regs_d;
        end
    end

    // Buffer has no reset; contents are only trusted below count
    always_ff @(posedge clk) begin
        if (push) begin
            mem[regs_q.wr_ptr] <= wdata[11:0];
        end
        mem_q <= mem[regs_q.rd_ptr];
    end

    assign rdata = regs_q.rdata;
    assign dac_data = regs_q.dac_data;
    assign dac_sel = regs_q.dac_sel;
    assign dac_write_strobe = regs_q.dac_strobe;
    assign dac_latch = regs_q.dac_latch;
    assign dac_ref_sel = regs_q.ref_sel;
    assign dac_bipolar = regs_q.bipolar;
    assign dma_req = regs_q.dma_req;
    assign fifo_full = regs_q.full;

endmodule // dgw_group_ctrl

/* rtl/dgw_defines.svh */
`ifndef DGW_DEFINES_SVH
`define DGW_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define DGW_REG_CTRL 8'h00
`define DGW_REG_CMD 8'h04
`define DGW_REG_CHAN 8'h08
`define DGW_REG_INTERVAL 8'h0c
`define DGW_REG_FIFO 8'h10
`define DGW_REG_STATUS 8'h14
`define DGW_REG_SWCODE 8'h20

// ****************************************
// Field positions
// ****************************************
`define DGW_CTRL_WAVE 0
`define DGW_CTRL_START_LSB 1
`define DGW_CTRL_STROBE_LSB 3
`define DGW_CTRL_STOP_LSB 5
`define DGW_CHAN_EN_LSB 0
`define DGW_CHAN_REF_LSB 4
`define DGW_CHAN_BIP_LSB 8
`define DGW_CMD_SW_UPDATE 0
`define DGW_CMD_SW_START 1
`define DGW_CMD_SW_STOP 2
`define DGW_CMD_ARM 3
`define DGW_CMD_FLUSH 4
`define DGW_CMD_CLEAR 5

// ****************************************
// Reset values and timing
// ****************************************
`define DGW_CODE_MID 12'h800
`define DGW_CLK_PERIOD_NS 40
`define DGW_MIN_UPDATE_NS 1000
`define DGW_MIN_UPDATE_CYC ((`DGW_MIN_UPDATE_NS + `DGW_CLK_PERIOD_NS - 1) / `DGW_CLK_PERIOD_NS)

`endif

/* rtl/dgw_pkg.sv */
package dgw_pkg;

    typedef logic [11:0] dgw_code_t;

    // Gray codes along idle, armed, run, fetch, shift, latch
    typedef enum logic [2:0] {
        DGW_IDLE = 3'h0,
        DGW_ARMED = 3'h1,
        DGW_RUN = 3'h3,
        DGW_FETCH = 3'h2,
        DGW_SHIFT = 3'h6,
        DGW_LATCH = 3'h7
    } dgw_state_t;

    typedef enum logic [1:0] {
        DGW_START_SW = 2'h0,
        DGW_START_EXT = 2'h1,
        DGW_START_ANALOG = 2'h2,
        DGW_START_SYNC = 2'h3
    } dgw_start_src_t;

    typedef enum logic [1:0] {
        DGW_STROBE_INT = 2'h0,
        DGW_STROBE_EXT = 2'h1,
        DGW_STROBE_SYNC = 2'h2,
        DGW_STROBE_OFF = 2'h3
    } dgw_strobe_src_t;

    typedef enum logic [1:0] {
        DGW_STOP_SW = 2'h0,
        DGW_STOP_EXT = 2'h1,
        DGW_STOP_ANALOG = 2'h2,
        DGW_STOP_NONE = 2'h3
    } dgw_stop_src_t;

endpackage

/* rtl/dgw_update_timer.sv */
`timescale 1ns/100ps
`include "dgw_defines.svh"

module dgw_update_timer (
    input wire logic clk, // 25 MHz clock
    input wire logic rst_n, // Asynchronous reset
    input wire logic run, // Count while high
    input wire logic [23:0] interval, // Cycles between ticks
    output logic tick // One-cycle update pulse
);
    import dgw_pkg::*;

    typedef struct packed {
        logic [23:0] cnt;
        logic tick;
    } dgw_timer_t;

    dgw_timer_t regs_q;
    dgw_timer_t regs_d;

    // Short intervals are stretched to the fastest legal update rate
    localparam logic [23:0] MIN_CYC = 24'(`DGW_MIN_UPDATE_CYC);

    always_comb begin
        logic [23:0] period;
        period = (interval < MIN_CYC) ? MIN_CYC : interval;
        regs_d = regs_q;
        regs_d.tick = 1'b0;
        if (!run) begin
            regs_d.cnt = 24'h000001;
        end else if (regs_q.cnt >= period) begin
            regs_d.cnt = 24'h000001;
            regs_d.tick = 1'b1;
        end else begin
            regs_d.cnt = regs_q.cnt + 24'h000001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regs_q <= '0;
        end else begin
            regs_q <= regs_d;
        end
    end

    assign tick = regs_q.tick;

endmodule // dgw_update_timer

/* verif/dgw_assertions.sv */
`timescale 1ns/100ps
// ****************************************
// Port checker for one converter group
// ****************************************
module dgw_chk (
    input wire logic clk, // Clock
    input wire logic rst_n, // Async reset
    input wire logic [7:0] addr, // Register address
    input wire logic [31:0] wdata, // Write data
    input wire logic wr_en, // Write strobe
    input wire dgw_pkg::dgw_code_t dac_data, // Converter code
    input wire logic [1:0] dac_sel, // Target converter
    input wire logic dac_write_strobe, // Converter write
    input wire logic dac_latch, // Group update
    input wire logic [3:0] dac_ref_sel, // Reference select
    input wire logic [3:0] dac_bipolar, // Polarity
    input wire logic dma_req, // Refill request
    input wire logic fifo_full // Buffer full
);
    import dgw_pkg::*;
    logic wave_q;
    logic chan_wr;
    logic [7:0] gap_q;
    logic [7:0] chan_q;
    assign chan_wr = wr_en && addr == 8'h08;
    // Mirrors of the written mode and channel setup
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wave_q <= 1'b0;
            gap_q <= 8'hff;
            chan_q <= 8'h00;
        end else begin
            if (wr_en && addr == 8'h00) wave_q <= wdata[0];
            if (chan_wr) chan_q <= wdata[11:4];
            gap_q <= dac_latch ? 8'h01 : (gap_q == 8'hff ? gap_q : gap_q + 8'h01);
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    a_strobe_pulse: assert property (dac_write_strobe |=> !dac_write_strobe)
        else $error("write strobe wider than one cycle");
    a_data_hold: assert property ($fell(dac_write_strobe) |-> $stable(dac_data) && $stable(dac_sel))
        else $error("code moved at strobe fall");
    a_latch_after: assert property (dac_latch |-> $past(dac_write_strobe, 2) && !$past(dac_write_strobe))
        else $error("latch not two cycles after last strobe");
    a_latch_pulse: assert property (dac_latch |=> !dac_latch)
        else $error("latch wider than one cycle");
    a_sel_ascend: assert property (dac_write_strobe && $past(dac_write_strobe, 2) |-> dac_sel > $past(dac_sel, 2))
        else $error("channels not written in ascending order");
    a_dma_full: assert property (fifo_full |-> !dma_req)
        else $error("refill requested while full");
    a_update_rate: assert property (wave_q && dac_latch |-> gap_q >= 8'd25)
        else $error("updates closer than one microsecond");
    a_ref_follow: assert property (!$past(chan_wr) && !$past(chan_wr, 2) |->
        dac_ref_sel == chan_q[3:0] && dac_bipolar == chan_q[7:4])
        else $error("reference or polarity differs from setup");
endmodule // dgw_chk

bind dgw_group_ctrl dgw_chk dgw_chk_inst (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .dac_data(dac_data), .dac_sel(dac_sel), .dac_write_strobe(dac_write_strobe),
    .dac_latch(dac_latch), .dac_ref_sel(dac_ref_sel), .dac_bipolar(dac_bipolar),
    .dma_req(dma_req), .fifo_full(fifo_full)
);

/* verif/dgw_dac_model.sv */
`timescale 1ns/100ps
// ****************************************
// Four converters with input and output registers
// ****************************************
module dgw_dac_model (
    input wire logic clk, // Clock
    input wire dgw_pkg::dgw_code_t dac_data, // Code in
    input wire logic [1:0] dac_sel, // Target converter
    input wire logic dac_write_strobe, // Write strobe
    input wire logic dac_latch, // Group update
    output logic [3:0][11:0] dac_out, // Output codes
    output logic [7:0] burst, // Writes in last update
    output logic [7:0] latches // Updates so far
);
    import dgw_pkg::*;
    logic [3:0][11:0] hold = '0;
    logic [7:0] pend = 8'h00;
    initial begin
        dac_out = '0;
        burst = 8'h00;
        latches = 8'h00;
    end
    // Time zero guard: the x to 0 settle is no write
    always @(negedge dac_write_strobe) begin
        if ($time > 0) begin
            hold[dac_sel] = dac_data;
            pend = pend + 8'h01;
        end
    end
    always @(posedge clk) begin
        if (dac_latch === 1'b1) begin
            dac_out <= hold;
            burst <= pend;
            pend = 8'h00;
            latches <= latches + 8'h01;
        end
    end
endmodule // dgw_dac_model

/* verif/dgw_group_ctrl_bench.sv */
`timescale 1ns/100ps
// ****************************************
// Group controller bench
// ****************************************
module dgw_group_ctrl_bench;
    import dgw_pkg::*;
    localparam int DEPTH = 16;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic ext_dig_trig = 1'b0;
    logic analog_trig = 1'b0;
    logic sync_bus_trigger = 1'b0;
    logic ext_update = 1'b1;
    logic sync_bus_update = 1'b1;
    logic [31:0] rdata;
    logic [31:0] v;
    dgw_code_t dac_data;
    logic [1:0] dac_sel;
    logic dac_write_strobe, dac_latch, dma_req, fifo_full;
    logic [3:0] dac_ref_sel, dac_bipolar;
    logic [3:0][11:0] dac_out;
    logic [7:0] burst, latches;
    logic [11:0] sw_code [4] = '{12'h000, 12'h800, 12'hfff, 12'h7ff};
    int errors = 0;
    int comparisons = 0;
    always #20 clk = ~clk;

    dgw_group_ctrl #(.FIFO_DEPTH(DEPTH)) dgw_group_ctrl_inst (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .ext_dig_trig(ext_dig_trig), .analog_trig(analog_trig),
        .sync_bus_trigger(sync_bus_trigger), .ext_update(ext_update),
        .sync_bus_update(sync_bus_update), .dac_data(dac_data), .dac_sel(dac_sel),
        .dac_write_strobe(dac_write_strobe), .dac_latch(dac_latch), .dac_ref_sel(dac_ref_sel),
        .dac_bipolar(dac_bipolar), .dma_req(dma_req), .fifo_full(fifo_full)
    );
    dgw_dac_model dgw_dac_model_inst (
        .clk(clk), .dac_data(dac_data), .dac_sel(dac_sel), .dac_write_strobe(dac_write_strobe),
        .dac_latch(dac_latch), .dac_out(dac_out), .burst(burst), .latches(latches)
    );

    // ****************************************
    // Access and check tasks
    // ****************************************
    task automatic wrap_up();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: register %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_dac(input logic [11:0] got, input logic [11:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: converter %h expected %h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Gap cycle after each access keeps strobes from being set twice at one edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        idle(1);
        wr_en <= 1'b0;
        idle(1);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        addr <= a;
        rd_en <= 1'b1;
        idle(1);
        rd_en <= 1'b0;
        #1 v = rdata;
        idle(1);
        chk_reg(v & m, e);
    endtask
    task automatic wait_latch(input logic [7:0] n);
        for (int i = 0; i < 400 && latches !== n; i++) idle(1);
        if (latches !== n) begin
            errors++;
            $display("CHECK FAILED at %0t: updates %h expected %h", $time, latches, n);
            wrap_up();
        end
    endtask
    // Rising edge on trigger pins, falling edge on update pins
    task automatic kick(input int p);
        case (p)
            1: ext_dig_trig <= 1'b1;
            2: analog_trig <= 1'b1;
            3: sync_bus_trigger <= 1'b1;
            4: ext_update <= 1'b0;
            default: sync_bus_update <= 1'b0;
        endcase
        idle(4);
        {ext_dig_trig, analog_trig, sync_bus_trigger} <= 3'b000;
        {ext_update, sync_bus_update} <= 2'b11;
        idle(4);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        idle(20);
        rst_n <= 1'b1;
        idle(1);
        for (int s = 0; s < 4; s++) rdc(8'h20 + 8'(4 * s), 32'hfff, 32'h800);
        rdc(8'h0c, 32'hffffff, 32'd25);
        rdc(8'h14, 32'h3fffff, 32'h40);
        rdc(8'h04, 32'hffffffff, 32'h0);
        rdc(8'h3c, 32'hffffffff, 32'h0);
        wr(8'h08, 32'h5ab);
        idle(2);
        chk_reg({24'h0, dac_bipolar, dac_ref_sel}, 32'h5a);
        rdc(8'h08, 32'hfff, 32'h5ab);
        for (int s = 0; s < 4; s++) wr(8'h20 + 8'(4 * s), {20'h0, sw_code[s]});
        wr(8'h04, 32'h1);
        wait_latch(8'h01);
        chk_dac(12'(burst), 12'h3);
        for (int s = 0; s < 4; s++) chk_dac(dac_out[s], s == 2 ? 12'h0 : sw_code[s]);
        wr(8'h04, 32'h1);
        wait_latch(8'h02);
        idle(40);
        chk_dac(12'(latches), 12'h2);
        // Waveform with internal, external and sync-bus strobes
        wr(8'h08, 32'h003);
        wr(8'h0c, 32'd30);
        for (int s = 0; s < 3; s++) begin
            wr(8'h00, 32'(1 + 8 * s));
            wr(8'h10, 32'(12'h1a0 + s));
            wr(8'h10, 32'(12'h2b0 + s));
            rdc(8'h14, 32'h3fff00, 32'h200);
            wr(8'h04, 32'h8);
            wr(8'h04, 32'h2);
            if (s != 0) begin
                kick(s + 3);
                kick(s + 3);
            end
            wait_latch(8'(3 + s));
            chk_dac(dac_out[0], 12'(12'h1a0 + s));
            chk_dac(dac_out[1], 12'(12'h2b0 + s));
            idle(40);
            chk_dac(12'(latches), 12'(3 + s));
            rdc(8'h14, 32'h10, s == 0 ? 32'h10 : 32'h0);
            wr(8'h04, 32'h4);
            rdc(8'h14, 32'h7, 32'h0);
            chk_reg({31'h0, dma_req}, 32'h1);
            wr(8'h04, 32'h20);
        end
        // Every start source, stop on its own source, except sync-bus start which is stopped by software
        for (int s = 0; s < 4; s++) begin
            wr(8'h00, 32'(25 + 2 * s + 32 * (s % 3)));
            wr(8'h04, 32'h8);
            rdc(8'h14, 32'h7, 32'h1);
            if (s == 0) wr(8'h04, 32'h2);
            else kick(s);
            rdc(8'h14, 32'h7, 32'h3);
            if (s % 3 == 0) begin
                if (s == 0) wr(8'h04, 32'h2);
                else kick(3);
                rdc(8'h14, 32'h7, 32'h3);
            end
            if (s % 3 == 0) wr(8'h04, 32'h4);
            else kick(s);
            rdc(8'h14, 32'h7, 32'h0);
        end
        // Fill past full, then flush
        wr(8'h00, 32'h79);
        for (int s = 0; s < DEPTH; s++) wr(8'h10, 32'(s));
        chk_reg({30'h0, fifo_full, dma_req}, 32'h2);
        wr(8'h10, 32'h5);
        rdc(8'h14, 32'h3fffb0, 32'(DEPTH * 256 + 32'ha0));
        wr(8'h04, 32'h10);
        rdc(8'h14, 32'h3fff40, 32'h40);
        chk_reg({30'h0, fifo_full, dma_req}, 32'h1);
        wrap_up();
    end
endmodule // dgw_group_ctrl_bench
